/* bench/irq_watch.sv */
module irq_watch (
  input  wire logic             clk,
  input  wire logic [1:0]       irq,
  output logic      [1:0][15:0] gap,
  output logic      [1:0][7:0]  rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]       irq_reg = 2'h0;
  logic [1:0][15:0] cnt_reg = '0;
  initial gap = '0;
  initial rises = '0;
  // counts request rises and cycles between them
  always @(posedge clk) begin
    irq_reg <= irq;
    for (int k = 0; k < 2; k++) begin
      cnt_reg[k] <= cnt_reg[k] + 16'h1;
      if (irq[k] && !irq_reg[k]) begin
        gap[k] <= cnt_reg[k] + 16'h1;
        cnt_reg[k] <= 16'h0;
        rises[k] <= rises[k] + 8'h1;
      end
    end
  end
endmodule

/* bench/pmt_check_assertions.sv */
`include "pmt_consts.svh"
module pmt_check
  import pmt_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire acc_size_t   size,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  match_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // read taken, and quiet requests
  sequence s_rd;
    rd && ce;
  endsequence
  sequence s_quiet;
    match_irq == 2'h0 [*7];
  endsequence
  // read port and request properties
  property p_rd_idle;
    $past(ce) && !$past(rd) |-> rdata == 32'h0;
  endproperty
  property p_run_rsv;
    s_rd ##0 (addr == `RUN_CTRL_ADDR && size == SZ_WORD) |=> rdata[15:2] == 14'h0;
  endproperty
  property p_long_per1;
    s_rd ##0 (addr == `CH1_PER_ADDR && size == SZ_LONG) |=> rdata == 32'h0;
  endproperty
  property p_unmapped;
    s_rd ##0 (addr == 32'hFFFF83DE) |=> rdata == 32'h0;
  endproperty
  property p_odd_word;
    s_rd ##0 (addr[0] && size == SZ_WORD) |=> rdata == 32'h0;
  endproperty
  property p_irq_level;
    $past(nrst) && !$past(wr) |-> ($past(match_irq) & ~match_irq) == 2'h0;
  endproperty
  property p_quiet;
    $rose(nrst) |-> s_quiet;
  endproperty
  property p_ce_hold;
    !ce |=> $stable(rdata);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  a_run_rsv: assert property (p_run_rsv) else $error("run bits 15:2 set");
  a_long_per1: assert property (p_long_per1) else $error("long read answered");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  a_odd_word: assert property (p_odd_word) else $error("odd word read answered");
  a_irq_level: assert property (p_irq_level) else $error("request dropped");
  a_quiet: assert property (p_quiet) else $error("early request");
  a_ce_hold: assert property (p_ce_hold) else $error("rdata moved with ce low");
endmodule
bind periodic_match_timer pmt_check u_chk (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr),
  .wdata(wdata), .size(size), .wr(wr), .rd(rd), .rdata(rdata), .match_irq(match_irq));

/* bench/tb_top.sv */
`include "pmt_consts.svh"
module tb_top
  import pmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 1'b0;
  logic             nrst, ce, wr, rd;
  logic [31:0]      addr, wdata, rdata, d;
  acc_size_t        size;
  logic [1:0]       match_irq;
  logic [1:0][15:0] gap;
  logic [1:0][7:0]  rises;
  int               num_errors = 0;
  int               n_tests = 0;
  logic [31:0]      bad_a [4] = '{32'hFFFF83DE, 32'hFFFF83D3, `CH1_PER_ADDR, `RUN_CTRL_ADDR};
  acc_size_t        bad_s [4] = '{SZ_WORD, SZ_WORD, SZ_LONG, acc_size_t'(2'h3)};
  // 20 MHz clock
  always #25 clk = ~clk;
  periodic_match_timer uut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .size(size), .wr(wr), .rd(rd), .rdata(rdata), .match_irq(match_irq));
  irq_watch ctl (.clk(clk), .irq(match_irq), .gap(gap), .rises(rises));
  // verdict and end of run
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bus cycles: strobe one cycle, then one idle edge
  task automatic wrr(input logic [31:0] a, input acc_size_t s, input logic [31:0] v);
    addr <= a;
    size <= s;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [31:0] a, input acc_size_t s, input logic [31:0] e);
    addr <= a;
    size <= s;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic wait_rise(input logic [7:0] n);
    int i;
    // slowest rate needs two ticks of 512 cycles plus phase slack
    for (i = 0; i < 20000 && rises[1] !== n; i++) @(posedge clk);
    if (rises[1] !== n) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    addr = 32'h0;
    wdata = 32'h0;
    size = SZ_WORD;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++)
      rdc(`BLK_BASE + 32'(2 * i), SZ_WORD, (i % 3 == 0 && i > 0) ? 32'hFFFF : 32'h0);
    wrr(`RUN_CTRL_ADDR, SZ_WORD, 32'h3);
    rdc(`RUN_CTRL_ADDR, SZ_WORD, 32'h3);
    wrr(`RUN_CTRL_ADDR, SZ_WORD, 32'h0);
    wrr(`CH0_CNT_ADDR, SZ_WORD, 32'h1234);
    repeat (40) @(posedge clk);
    rdc(`CH0_CNT_ADDR, SZ_WORD, 32'h1234);
    rdc(`CH0_CNT_ADDR, SZ_LONG, 32'h1234FFFF);
    rdc(`CH0_CNT_ADDR + 32'h1, SZ_BYTE, 32'h34);
    for (int i = 0; i < 4; i++) rdc(bad_a[i], bad_s[i], 32'h0);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    // every clock select, period 1 on channel 1
    for (int c = 0; c < 4; c++) begin
      wrr(`CH1_PER_ADDR, SZ_WORD, 32'h1);
      wrr(`CH1_CSR_ADDR, SZ_WORD, 32'h40 | 32'(c));
      wrr(`CH1_CNT_ADDR, SZ_WORD, 32'h0);
      wrr(`RUN_CTRL_ADDR, SZ_WORD, 32'h2);
      repeat (2) begin
        wait_rise(rises[1] + 8'h1);
        rdc(`CH1_CSR_ADDR, SZ_WORD, 32'hC0 | 32'(c));
        wrr(`CH1_CSR_ADDR, SZ_WORD, 32'h40 | 32'(c));
      end
      chk(32'(gap[1]), 32'h10 << (2 * c));
      wrr(`RUN_CTRL_ADDR, SZ_WORD, 32'h0);
    end
    // flag clearing needs a read first
    wrr(`RUN_CTRL_ADDR, SZ_WORD, 32'h2);
    wait_rise(rises[1] + 8'h1);
    wrr(`RUN_CTRL_ADDR, SZ_WORD, 32'h0);
    wrr(`CH1_CSR_ADDR, SZ_WORD, 32'h40);
    chk(32'(match_irq), 32'h2);
    rdc(`CH1_CSR_ADDR, SZ_WORD, 32'hC0);
    wrr(`CH1_CSR_ADDR, SZ_WORD, 32'hC0);
    chk(32'(match_irq), 32'h2);
    rdc(`CH1_CSR_ADDR, SZ_WORD, 32'hC0);
    wrr(`CH1_CSR_ADDR, SZ_WORD, 32'h40);
    chk(32'(match_irq), 32'h0);
    rdc(`CH1_CSR_ADDR, SZ_WORD, 32'h40);
    wrr(`CH1_CSR_ADDR, SZ_WORD, 32'h0);
    wrr(`CH1_CSR_ADDR, SZ_WORD, 32'h80);
    rdc(`CH1_CSR_ADDR, SZ_WORD, 32'h0);
    wrap_up();
  end
endmodule

/* hw/periodic_match_timer.sv */
// Behaviour
// - two independent channels, each a 16-bit up-counter with 16-bit period register.
// - clock select 00..11 picks phi/8, phi/32, phi/128, phi/512.
// - run control bit 1 runs channel 1, bit 0 channel 0; reset halted.
// - run control bits 15..2 read zero; software writes zero there.
// - counter steps once per selected divided pulse, only while its run bit set.
// - counter equal to period clears counter and sets the match flag.
// - after clearing, counting resumes from zero; period is value plus one.
// - each channel raises its own request when flag and enable are both one.
// - match acts on the counting pulse that would leave the equal value.
// - flag clears only by reading it as one, then writing zero.
// - writing one to the match flag leaves it set but cancels the clear armed by a read.
// - match clear beats a simultaneous counter write; the write is lost.
// - word write to counter beats a simultaneous increment; increment dropped.
// - byte write with increment stores byte; other byte keeps old value.
// - reset loads periods with all ones, everything else with zero.
// - all registers take 8, 16, 32-bit access; channel 1 period 8 and 16.
`include "pmt_consts.svh"

module periodic_match_timer
  import pmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire acc_size_t   size,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic      [1:0]  match_irq
);

  localparam chan_t CH_RST = '{
    cnt:   `COUNT_RESET,
    per:   `PERIOD_RESET,
    flag:  1'b0,
    ie:    1'b0,
    cks:   `CSR_CKS_RESET,
    armed: 1'b0
  };
  localparam tmr_state_t ST_RST = '{
    presc: '0,
    run:   `RUN_RESET,
    ch:    '{CH_RST, CH_RST},
    rdata: '0
  };
  localparam logic [2:0] CSR_IDX [2] = '{`IDX_CSR0, `IDX_CSR1};
  localparam logic [2:0] CNT_IDX [2] = '{`IDX_CNT0, `IDX_CNT1};
  localparam logic [2:0] PER_IDX [2] = '{`IDX_PER0, `IDX_PER1};

  tmr_state_t  st_reg;
  tmr_state_t  st_next;
  logic        in_blk;
  logic [2:0]  idx;
  logic [15:0] hw_val [8];
  logic [1:0]  wm     [8];
  logic [15:0] wv     [8];
  logic [1:0]  rm     [8];
  logic [31:0] rd_val;

  // byte lanes of halfword register i hit by an access (hi, lo)
  function automatic logic [1:0] lane_mask(
    input logic [31:0] a,
    input acc_size_t   sz,
    input logic [2:0]  i
  );
    logic [1:0] m;
    m = 2'b00;
    case (sz)
      SZ_BYTE: begin
        if (a[3:1] == i) m = a[0] ? 2'b01 : 2'b10;
      end
      SZ_WORD: begin
        if (!a[0] && a[3:1] == i) m = 2'b11;
      end
      SZ_LONG: begin
        // long access to channel 1 period is refused
        if (a[1:0] == 2'b00 && a[3:2] == i[2:1] && a[3:1] != `IDX_PER1) m = 2'b11;
      end
      default: m = 2'b00;
    endcase
    return m;
  endfunction

  // write data seen by halfword register i (big-endian lanes)
  function automatic logic [15:0] lane_val(
    input acc_size_t   sz,
    input logic [31:0] d,
    input logic [2:0]  i
  );
    logic [15:0] v;
    case (sz)
      SZ_BYTE: v = {d[7:0], d[7:0]};
      SZ_LONG: v = i[0] ? d[15:0] : d[31:16];
      default: v = d[15:0];
    endcase
    return v;
  endfunction

  // replace only the written byte lanes
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [15:0] v,
    input logic [1:0]  m
  );
    logic [15:0] keep;
    keep = {{8{m[1]}}, {8{m[0]}}};
    return (old & ~keep) | (v & keep);
  endfunction

  // control/status word of one channel
  function automatic logic [15:0] csr_word(input chan_t c);
    logic [15:0] v;
    v = 16'h0000;
    v[`CSR_FLAG_BIT] = c.flag;
    v[`CSR_IE_BIT] = c.ie;
    v[`CSR_CKS_HI:`CSR_CKS_LO] = c.cks;
    return v;
  endfunction

  // one-cycle enable from the shared prescaler for the selected rate
  function automatic logic div_tick(
    input logic [`PRESC_W-1:0] p,
    input logic [1:0]          cks
  );
    logic t;
    case (cks)
      2'h0:    t = &p[`DIV8_MSB:0];
      2'h1:    t = &p[`DIV32_MSB:0];
      2'h2:    t = &p[`DIV128_MSB:0];
      2'h3:    t = &p[`DIV512_MSB:0];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // address decode
  assign in_blk = (addr & `BLK_ADDR_MASK) == `BLK_BASE;
  assign idx    = addr[3:1];

  // register read view; reserved bits are zero
  always_comb begin
    hw_val[`IDX_RUN]  = {14'h0000, st_reg.run};
    hw_val[`IDX_CSR0] = csr_word(st_reg.ch[0]);
    hw_val[`IDX_CNT0] = st_reg.ch[0].cnt;
    hw_val[`IDX_PER0] = st_reg.ch[0].per;
    hw_val[`IDX_CSR1] = csr_word(st_reg.ch[1]);
    hw_val[`IDX_CNT1] = st_reg.ch[1].cnt;
    hw_val[`IDX_PER1] = st_reg.ch[1].per;
    hw_val[`IDX_NONE] = 16'h0000;
  end

  // per-register lane masks and write data
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wm[i] = (wr && in_blk) ? lane_mask(addr, size, 3'(i)) : 2'b00;
      rm[i] = (rd && in_blk) ? lane_mask(addr, size, 3'(i)) : 2'b00;
      wv[i] = lane_val(size, wdata, 3'(i));
    end
  end

  // read data mux; unmapped or refused reads give zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (size)
      SZ_BYTE: rd_val = {24'h000000, addr[0] ? hw_val[idx][7:0] : hw_val[idx][15:8]};
      SZ_WORD: begin
        if (!addr[0]) rd_val = {16'h0000, hw_val[idx]};
      end
      SZ_LONG: begin
        if (addr[1:0] == 2'b00 && idx != `IDX_PER1) begin
          rd_val = {hw_val[idx], hw_val[idx | 3'h1]};
        end
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // next state of the whole block
  always_comb begin
    chan_t      c;
    chan_t      nc;
    logic       tick;
    logic       match;
    logic [2:0] ci;
    logic [2:0] ni;
    logic [2:0] pi;
    c     = CH_RST;
    nc    = CH_RST;
    tick  = 1'b0;
    match = 1'b0;
    ci    = 3'h0;
    ni    = 3'h0;
    pi    = 3'h0;
    st_next = st_reg;
    if (ce) begin
      st_next.presc = st_reg.presc + 9'h001;
      st_next.rdata = 32'h0000_0000;
      if (rd && in_blk) st_next.rdata = rd_val;
      // run bits live in the low byte only
      if (wm[`IDX_RUN][0]) begin
        st_next.run[`RUN_CH0_BIT] = wv[`IDX_RUN][`RUN_CH0_BIT];
        st_next.run[`RUN_CH1_BIT] = wv[`IDX_RUN][`RUN_CH1_BIT];
      end
      for (int k = 0; k < 2; k++) begin
        c     = st_reg.ch[k];
        nc    = c;
        ci    = CSR_IDX[k];
        ni    = CNT_IDX[k];
        pi    = PER_IDX[k];
        tick  = st_reg.run[k] && div_tick(st_reg.presc, c.cks);
        match = tick && (c.cnt == c.per);
        // reading the flag as one arms the clear
        if (rm[ci][0] && c.flag) nc.armed = 1'b1;
        // control/status write; a one to the flag is ignored
        if (wm[ci][0]) begin
          nc.ie  = wv[ci][`CSR_IE_BIT];
          nc.cks = wv[ci][`CSR_CKS_HI:`CSR_CKS_LO];
          if (!wv[ci][`CSR_FLAG_BIT] && c.armed) nc.flag = 1'b0;
          nc.armed = 1'b0;
        end
        // period register
        nc.per = merge(c.per, wv[pi], wm[pi]);
        // counter: match clear, then write, then increment
        if (match) begin
          nc.cnt  = 16'h0000;
          nc.flag = 1'b1;
        end else if (|wm[ni]) begin
          nc.cnt = merge(c.cnt, wv[ni], wm[ni]);
        end else if (tick) begin
          nc.cnt = c.cnt + 16'h0001;
        end
        st_next.ch[k] = nc;
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign rdata = st_reg.rdata;
  assign match_irq[0] = st_reg.ch[0].flag & st_reg.ch[0].ie;
  assign match_irq[1] = st_reg.ch[1].flag & st_reg.ch[1].ie;

endmodule

/* hw/pmt_consts.svh */
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// block base and register byte addresses
`define BLK_BASE        32'hFFFF83D0
`define BLK_ADDR_MASK   32'hFFFFFFF0
`define RUN_CTRL_ADDR   32'hFFFF83D0
`define CH0_CSR_ADDR    32'hFFFF83D2
`define CH0_CNT_ADDR    32'hFFFF83D4
`define CH0_PER_ADDR    32'hFFFF83D6
`define CH1_CSR_ADDR    32'hFFFF83D8
`define CH1_CNT_ADDR    32'hFFFF83DA
`define CH1_PER_ADDR    32'hFFFF83DC

// halfword index of each register inside the block
`define IDX_RUN         3'h0
`define IDX_CSR0        3'h1
`define IDX_CNT0        3'h2
`define IDX_PER0        3'h3
`define IDX_CSR1        3'h4
`define IDX_CNT1        3'h5
`define IDX_PER1        3'h6
`define IDX_NONE        3'h7

// field positions
`define RUN_CH0_BIT     0
`define RUN_CH1_BIT     1
`define CSR_FLAG_BIT    7
`define CSR_IE_BIT      6
`define CSR_CKS_HI      1
`define CSR_CKS_LO      0

// reset values
`define RUN_RESET       2'h0
`define CSR_CKS_RESET   2'h0
`define COUNT_RESET     16'h0000
`define PERIOD_RESET    16'hFFFF

// prescaler: top bit of the all-ones window for phi/8, /32, /128, /512
`define PRESC_W         9
`define DIV8_MSB        2
`define DIV32_MSB       4
`define DIV128_MSB      6
`define DIV512_MSB      8

`endif

/* hw/pmt_pkg.sv */
package pmt_pkg;

  // access width on the register port
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } acc_size_t;

  // per-channel state
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] per;
    logic        flag;
    logic        ie;
    logic [1:0]  cks;
    logic        armed;
  } chan_t;

  // whole block state
  typedef struct packed {
    logic [8:0]  presc;
    logic [1:0]  run;
    chan_t [1:0] ch;
    logic [31:0] rdata;
  } tmr_state_t;

endpackage
